// File: inc/switch_pkg.sv
/*
  Shared constants and types for the two-wire target of the eight-channel bus switch.
  Assumes it is compiled before every design file that imports it.
*/
`default_nettype none

package switch_pkg;

  localparam int          BYTE_BITS         = 8;
  localparam logic [3:0]  ACK_SLOT          = 4'h8;
  localparam logic [3:0]  COUNT_RESET       = 4'h0;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  CHAN_RESET        = 8'h00;
  localparam logic [3:0]  ADDR_HIGH_DEFAULT = 4'hA;  // Arbitrary value
  localparam logic [1:0]  LINE_SYNC_RESET   = 2'h3;
  localparam logic [1:0]  RSTN_SYNC_RESET   = 2'h0;
  localparam logic [2:0]  TOG_SYNC_RESET    = 3'h0;
  localparam logic [1:0]  BIT_SYNC_RESET    = 2'h3;
  localparam logic [2:0]  ADDR_SYNC_RESET   = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK_OUT,
    ST_SEND,
    ST_ACK_IN,
    ST_IGNORE
  } bus_state_type;

  typedef struct packed {
    bus_state_type st;
    logic [3:0]    cnt;
    logic [7:0]    shift;
    logic          is_addr;
    logic          rd;
    logic          nack;
    logic          sda_oe;
    logic          busy;
    logic [7:0]    ctrl;
    logic [7:0]    chan;
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic          scl_prev;
    logic          sda_prev;
    logic [1:0]    rstn_sync;
    logic [2:0]    addr_sync0;
    logic [2:0]    addr_sync1;
    logic [2:0]    tog_sync;
    logic          tog_prev;
    logic [1:0]    bit_sync;
  } core_state_type;

  typedef struct packed {
    logic bit_val;
    logic tog;
  } link_state_type;

endpackage : switch_pkg

`default_nettype wire

// File: hw/link_sampler.sv
/*
  Bit sampler running on the serial clock of the upstream bus.
  Assumes the serial clock pin is wired as bus_clk and may stop between frames.
*/
`timescale 1ns/1ns
`default_nettype none

module link_sampler
  import switch_pkg::*;
(
  input  wire logic bus_clk,
  input  wire logic sys_rst,
  input  wire logic sda_in,
  output logic      link_bit,
  output logic      link_toggle
);

  link_state_type state_r;
  link_state_type state_nxt;

  // One data bit taken per clock pulse, at the rising edge
  always_comb begin
    state_nxt         = state_r;
    state_nxt.bit_val = sda_in;
    state_nxt.tog     = ~state_r.tog;
  end

  // Async assert is safe here: only constants are loaded
  always_ff @(posedge bus_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '{bit_val: 1'b1, tog: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link_bit    = state_r.bit_val;
  assign link_toggle = state_r.tog;

endmodule : link_sampler

`default_nettype wire

// File: hw/bus_switch_target.sv
/*
  Two-wire target logic of an eight-channel bus switch: control byte, channel enables.
  Assumes scl_in and bus_clk carry the same serial clock pin and that sda is open drain.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_switch_target
  import switch_pkg::*;
#(
  parameter logic [3:0] ADDR_HIGH = ADDR_HIGH_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       bus_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       reset_n_in,
  input  wire logic [2:0] addr_pins,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      channel_enable,
  output logic [7:0]      control_byte,
  output logic            bus_busy
);

  core_state_type state_r;
  core_state_type state_nxt;

  logic link_bit;
  logic link_toggle;

  link_sampler u_link (
    .bus_clk     (bus_clk),
    .sys_rst     (sys_rst),
    .sda_in      (sda_in),
    .link_bit    (link_bit),
    .link_toggle (link_toggle)
  );

  // Open drain: pull low for a zero, release for a one
  function automatic logic send_oe(input logic [7:0] byte_v);
    send_oe = ~byte_v[7];
  endfunction : send_oe

  logic       scl_now;
  logic       sda_now;
  logic       scl_high;
  logic       start_ev;
  logic       stop_ev;
  logic       fall_ev;
  logic       rise_ev;
  logic       rx_bit;
  logic       addr_hit;
  logic [7:0] shifted;

  assign scl_now  = state_r.scl_sync[1];
  assign sda_now  = state_r.sda_sync[1];
  assign scl_high = scl_now & state_r.scl_prev;
  assign start_ev = scl_high & state_r.sda_prev & ~sda_now;
  assign stop_ev  = scl_high & ~state_r.sda_prev & sda_now;
  assign fall_ev  = state_r.scl_prev & ~scl_now;
  // Edge seen one stage after the bit sync, so the bit has settled first
  assign rise_ev  = state_r.tog_sync[2] ^ state_r.tog_prev;
  assign rx_bit   = state_r.bit_sync[1];
  assign addr_hit = (state_r.shift[7:1] == {ADDR_HIGH, state_r.addr_sync1});
  assign shifted  = {state_r.shift[6:0], 1'b0};

  always_comb begin
    state_nxt            = state_r;
    state_nxt.scl_sync   = {state_r.scl_sync[0], scl_in};
    state_nxt.sda_sync   = {state_r.sda_sync[0], sda_in};
    state_nxt.scl_prev   = state_r.scl_sync[1];
    state_nxt.sda_prev   = state_r.sda_sync[1];
    state_nxt.rstn_sync  = {state_r.rstn_sync[0], reset_n_in};
    state_nxt.addr_sync0 = addr_pins;
    state_nxt.addr_sync1 = state_r.addr_sync0;
    state_nxt.tog_sync   = {state_r.tog_sync[1:0], link_toggle};
    state_nxt.tog_prev   = state_r.tog_sync[2];
    state_nxt.bit_sync   = {state_r.bit_sync[0], link_bit};

    if (!state_r.rstn_sync[1]) begin
      state_nxt.st     = ST_IDLE;
      state_nxt.cnt    = COUNT_RESET;
      state_nxt.ctrl   = CTRL_RESET;
      state_nxt.chan   = CHAN_RESET;
      state_nxt.sda_oe = 1'b0;
      state_nxt.busy   = 1'b0;
    end else if (start_ev) begin
      // Start, also repeated start, aborts whatever was in flight
      state_nxt.st      = ST_RECV;
      state_nxt.is_addr = 1'b1;
      state_nxt.cnt     = COUNT_RESET;
      state_nxt.sda_oe  = 1'b0;
      state_nxt.busy    = 1'b1;
    end else if (stop_ev) begin
      state_nxt.st     = ST_IDLE;
      state_nxt.sda_oe = 1'b0;
      state_nxt.busy   = 1'b0;
      state_nxt.chan   = state_r.ctrl;
    end else begin
      unique case (state_r.st)
        ST_IDLE, ST_IGNORE: begin
          state_nxt.sda_oe = 1'b0;
        end
        ST_RECV: begin
          if (rise_ev && state_r.cnt < ACK_SLOT) begin
            state_nxt.shift = {state_r.shift[6:0], rx_bit};
            state_nxt.cnt   = state_r.cnt + 4'h1;
          end
          if (fall_ev && state_r.cnt == ACK_SLOT) begin
            state_nxt.cnt = COUNT_RESET;
            if (state_r.is_addr) begin
              if (addr_hit) begin
                state_nxt.rd     = state_r.shift[0];
                state_nxt.sda_oe = 1'b1;
                state_nxt.st     = ST_ACK_OUT;
              end else begin
                state_nxt.st = ST_IGNORE;
              end
            end else begin
              state_nxt.ctrl   = state_r.shift;
              state_nxt.sda_oe = 1'b1;
              state_nxt.st     = ST_ACK_OUT;
            end
          end
        end
        ST_ACK_OUT: begin
          // Held from the eighth fall to the ninth fall, spanning the high phase
          if (fall_ev) begin
            state_nxt.is_addr = 1'b0;
            state_nxt.cnt     = COUNT_RESET;
            if (state_r.rd) begin
              state_nxt.shift  = state_r.ctrl;
              state_nxt.sda_oe = send_oe(state_r.ctrl);
              state_nxt.st     = ST_SEND;
            end else begin
              state_nxt.sda_oe = 1'b0;
              state_nxt.st     = ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (rise_ev) begin
            state_nxt.cnt = state_r.cnt + 4'h1;
          end
          if (fall_ev) begin
            if (state_r.cnt == ACK_SLOT) begin
              state_nxt.sda_oe = 1'b0;
              state_nxt.st     = ST_ACK_IN;
            end else begin
              state_nxt.shift  = shifted;
              state_nxt.sda_oe = send_oe(shifted);
            end
          end
        end
        ST_ACK_IN: begin
          if (rise_ev) begin
            state_nxt.nack = rx_bit;
          end
          if (fall_ev) begin
            state_nxt.cnt = COUNT_RESET;
            if (state_r.nack) begin
              state_nxt.sda_oe = 1'b0;
              state_nxt.st     = ST_IGNORE;
            end else begin
              state_nxt.shift  = state_r.ctrl;
              state_nxt.sda_oe = send_oe(state_r.ctrl);
              state_nxt.st     = ST_SEND;
            end
          end
        end
        default: begin
          state_nxt.st     = ST_IDLE;
          state_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '{
        st:         ST_IDLE,
        cnt:        COUNT_RESET,
        shift:      CTRL_RESET,
        is_addr:    1'b0,
        rd:         1'b0,
        nack:       1'b1,
        sda_oe:     1'b0,
        busy:       1'b0,
        ctrl:       CTRL_RESET,
        chan:       CHAN_RESET,
        scl_sync:   LINE_SYNC_RESET,
        sda_sync:   LINE_SYNC_RESET,
        scl_prev:   1'b1,
        sda_prev:   1'b1,
        rstn_sync:  RSTN_SYNC_RESET,
        addr_sync0: ADDR_SYNC_RESET,
        addr_sync1: ADDR_SYNC_RESET,
        tog_sync:   TOG_SYNC_RESET,
        tog_prev:   1'b0,
        bit_sync:   BIT_SYNC_RESET
      };
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sda_out        = 1'b0;
  assign sda_oe         = state_r.sda_oe;
  assign channel_enable = state_r.chan;
  assign control_byte   = state_r.ctrl;
  assign bus_busy       = state_r.busy;

endmodule : bus_switch_target

`default_nettype wire

// File: test/bus_switch_assertions.sv
/*
  Port-level checks of the bus switch target, bound into bus_switch_target.
  Assumes scl_in and sda_in carry the resolved bus lines.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_switch_checker
  import switch_pkg::*;
#(
  parameter logic [3:0] ADDR_HIGH = ADDR_HIGH_DEFAULT
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       bus_clk,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       reset_n_in,
  input wire logic [2:0] addr_pins,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] channel_enable,
  input wire logic [7:0] control_byte,
  input wire logic       bus_busy
);
  a_open_drain: assert property (@(posedge sys_clk) disable iff (sys_rst) !sda_out)
    else $error("sda_out driven high");
  a_start_busy: assert property (@(posedge sys_clk) disable iff (sys_rst || !reset_n_in)
    scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] bus_busy)
    else $error("start not seen");
  a_stop_idle: assert property (@(posedge sys_clk) disable iff (sys_rst || !reset_n_in)
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  a_oe_scl_low: assert property (@(posedge sys_clk) disable iff (sys_rst || !reset_n_in)
    $changed(sda_oe) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
    else $error("sda_oe moved while clock high");
  a_idle_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bus_busy && !$past(bus_busy) |-> !sda_oe)
    else $error("data pulled while idle");
  a_chan_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(channel_enable) |-> !bus_busy)
    else $error("channels changed inside frame");
  a_chan_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(channel_enable) |-> channel_enable == control_byte)
    else $error("channels differ from control byte");
  a_ctrl_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(control_byte) |-> bus_busy || control_byte == CTRL_RESET)
    else $error("control byte changed outside frame");
  a_pin_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !reset_n_in [*5] |-> channel_enable == CHAN_RESET && control_byte == CTRL_RESET
      && !bus_busy && !sda_oe)
    else $error("reset pin did not clear");
endmodule : bus_switch_checker

bind bus_switch_target bus_switch_checker #(.ADDR_HIGH(ADDR_HIGH)) chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_clk(bus_clk), .scl_in(scl_in),
  .sda_in(sda_in), .reset_n_in(reset_n_in), .addr_pins(addr_pins), .sda_out(sda_out),
  .sda_oe(sda_oe), .channel_enable(channel_enable), .control_byte(control_byte),
  .bus_busy(bus_busy));

`default_nettype wire

// File: test/bus_master_model.sv
/*
  Upstream bus master model: drives the clock and pulls data low.
  Assumes sda is the resolved wire with a pull-up; phases are 24 clk cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Phases well above the few cycles of three-stage sync latency the target needs
  task automatic phase();
    repeat (24) @(posedge clk);
  endtask : phase
  // Also serves as repeated start
  task automatic start();
    pull <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    pull <= 1'b1;
    phase();
    scl <= 1'b0;
    phase();
  endtask : start
  task automatic put_bit(input logic b);
    pull <= !b;
    phase();
    scl <= 1'b1;
    phase();
    scl <= 1'b0;
    phase();
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    pull <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    ack = !sda;
    scl <= 1'b0;
    phase();
  endtask : send_byte
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pull <= 1'b0;
      phase();
      scl <= 1'b1;
      phase();
      b[i] = sda;
      scl <= 1'b0;
      phase();
    end
    put_bit(!ack);
  endtask : recv_byte
  task automatic stop();
    pull <= 1'b1;
    phase();
    scl <= 1'b1;
    phase();
    pull <= 1'b0;
    phase();
  endtask : stop
endmodule : bus_master_model

`default_nettype wire

// File: test/tb_top.sv
/*
  Self-checking bench of the bus switch target with a master model.
  Assumes the target is addressed by ADDR_HIGH_DEFAULT and addr_pins.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import switch_pkg::*;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reset_n_in = 1'b1;
  logic [2:0] pins = 3'h5;
  logic       scl;
  logic       pull;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] channel_enable;
  logic [7:0] control_byte;
  logic       bus_busy;
  int         mismatches = 0;
  int         checks_done = 0;
  wire logic  sda = !(pull || (sda_oe && !sda_out));

  initial forever #4 sys_clk = !sys_clk;

  bus_master_model m_u (.clk(sys_clk), .sda(sda), .scl(scl), .pull(pull));
  bus_switch_target dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_clk(scl),
    .scl_in(scl), .sda_in(sda), .reset_n_in(reset_n_in), .addr_pins(pins),
    .sda_out(sda_out), .sda_oe(sda_oe), .channel_enable(channel_enable),
    .control_byte(control_byte), .bus_busy(bus_busy));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic t_write();
    logic a;
    m_u.start();
    m_u.send_byte({ADDR_HIGH_DEFAULT, pins, 1'b0}, a);
    check("addr ack", 8'h01, {7'h00, a});
    m_u.send_byte(8'h3C, a);
    check("data ack", 8'h01, {7'h00, a});
    m_u.send_byte(8'h81, a);
    check("data ack", 8'h01, {7'h00, a});
    check("control", 8'h81, control_byte);
    check("chan early", 8'h00, channel_enable);
    m_u.stop();
    repeat (8) @(posedge sys_clk);
    check("chan", 8'h81, channel_enable);
    check("busy", 8'h00, {7'h00, bus_busy});
  endtask : t_write

  task automatic t_read();
    logic       a;
    logic [7:0] b;
    m_u.start();
    m_u.send_byte({ADDR_HIGH_DEFAULT, pins, 1'b0}, a);
    m_u.send_byte(8'h42, a);
    m_u.start();
    m_u.send_byte({ADDR_HIGH_DEFAULT, pins, 1'b1}, a);
    check("read ack", 8'h01, {7'h00, a});
    m_u.recv_byte(1'b1, b);
    check("read 1", 8'h42, b);
    m_u.recv_byte(1'b0, b);
    check("read 2", 8'h42, b);
    check("released", 8'h00, {7'h00, sda_oe});
    m_u.stop();
    repeat (8) @(posedge sys_clk);
    check("chan", 8'h42, channel_enable);
  endtask : t_read

  task automatic t_bad_addr();
    logic a;
    m_u.start();
    m_u.send_byte({ADDR_HIGH_DEFAULT, ~pins, 1'b0}, a);
    check("bad ack", 8'h00, {7'h00, a});
    m_u.send_byte(8'hFF, a);
    check("ignored", 8'h00, {7'h00, a});
    m_u.stop();
    check("control", 8'h42, control_byte);
  endtask : t_bad_addr

  task automatic t_reset_pin();
    reset_n_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("control", CTRL_RESET, control_byte);
    check("chan", CHAN_RESET, channel_enable);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask : t_reset_pin

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("chan", CHAN_RESET, channel_enable);
    t_write();
    t_read();
    t_bad_addr();
    t_reset_pin();
    t_write();
    end_of_test();
  end

  initial begin
    // About five times the expected run, well under the cycle budget
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
